// ==== clkgen_regs.svh ====
// register offsets, field positions, reset values and timing counts of the clock unit
`ifndef CLKGEN_REGS_SVH
`define CLKGEN_REGS_SVH

// ============================================================
// register byte offsets
`define CG_TRIM_OFS 4'h0
`define CG_DIV_OFS 4'h4
`define CG_STAT_OFS 4'h8

// ============================================================
// trim register fields
`define CG_TRIM_LSB 0
`define CG_TRIM_W 6
`define CG_CLKOUT_EN_BIT 6
`define CG_FACTORY_TRIM 6'h20

// ============================================================
// divider and status fields
`define CG_DIV_W 8
`define CG_DIV_RESET 8'h00
`define CG_STAT_WAKE_BIT 0
`define CG_STAT_CLKOUT_BIT 1
`define CG_STAT_SRC_LSB 2
`define CG_STAT_RTC_BIT 5

// ============================================================
// wake-up timing
`define CG_XTAL_WAKE_CYC 10'd992
`define CG_OTHER_WAKE_CYC 10'd224
`define CG_WAKE_MIN_NS 60000
`define CG_WAKE_MAX_NS 100000
`define CG_CLK_PERIOD_NS 25
`define CG_WAKE_MIN_CYC ((`CG_WAKE_MIN_NS + `CG_CLK_PERIOD_NS - 1) / `CG_CLK_PERIOD_NS)

`endif

// ==== clkgen_pkg.sv ====
// types shared by the clock generation unit
package clkgen_pkg;

    // ============================================================
    // oscillator source chosen by the stored configuration
    typedef enum logic [2:0] {
        src_xtal_low,
        src_xtal_med,
        src_xtal_high,
        src_rc,
        src_wdt,
        src_ext
    } osc_src_e;

    // ============================================================
    // wake-up timer states
    typedef enum logic [1:0] {
        wk_idle,
        wk_count,
        wk_done
    } wake_state_e;

endpackage

// ==== clkgen_wake_timer.sv ====
// wake-up delay timer that withholds the cpu clock until the oscillator settles
`timescale 1ns/1ps
`include "clkgen_regs.svh"

module clkgen_wake_timer (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // control
    input wire logic start,
    input wire logic stop,
    input wire logic osc_tick,
    input wire logic long_wait,
    // status
    output logic done
);
    import clkgen_pkg::*;

    localparam logic [11:0] TIME_CYC = 12'(`CG_WAKE_MIN_CYC);

    wake_state_e state, next_state;
    logic [9:0] osc_cnt, next_osc_cnt;
    logic [11:0] time_cnt, next_time_cnt;
    logic [9:0] target, next_target;

    // ============================================================
    // next state
    always_comb begin
        next_state = state;
        next_osc_cnt = osc_cnt;
        next_time_cnt = time_cnt;
        next_target = target;
        case (state)
            wk_idle: begin
                if (start) begin
                    next_state = wk_count;
                    next_osc_cnt = 10'h000;
                    next_time_cnt = 12'h000;
                    next_target = long_wait ? `CG_XTAL_WAKE_CYC : `CG_OTHER_WAKE_CYC;
                end
            end
            wk_count: begin
                if (osc_tick && osc_cnt != target) begin
                    next_osc_cnt = osc_cnt + 10'h001;
                end
                if (time_cnt != TIME_CYC) begin
                    next_time_cnt = time_cnt + 12'h001;
                end
                // both the cycle count and the settling time must pass
                if (osc_cnt == target && time_cnt == TIME_CYC) begin
                    next_state = wk_done;
                end
            end
            wk_done: begin
                next_state = wk_done;
            end
            default: begin
                next_state = wk_idle;
            end
        endcase
        if (stop) begin
            next_state = wk_idle;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= wk_idle;
            osc_cnt <= 10'h000;
            time_cnt <= 12'h000;
            target <= `CG_OTHER_WAKE_CYC;
        end else begin
            state <= next_state;
            osc_cnt <= next_osc_cnt;
            time_cnt <= next_time_cnt;
            target <= next_target;
        end
    end

    assign done = (state == wk_done);

    // ============================================================
    // checks
    property p_done_after_both;
        @(posedge core_clk) disable iff (!rst_n)
        $rose(done) |-> $past(osc_cnt) == $past(target) && $past(time_cnt) == TIME_CYC;
    endproperty
    a_done_after_both: assert property (p_done_after_both) else $error("release before delay ended");

    property p_target_sel;
        @(posedge core_clk) disable iff (!rst_n)
        state == wk_idle && start && !stop |=> target == ($past(long_wait) ? 10'd992 : 10'd224);
    endproperty
    a_target_sel: assert property (p_target_sel) else $error("wrong wake cycle count");

    property p_stop_clears;
        @(posedge core_clk) disable iff (!rst_n)
        stop |=> !done;
    endproperty
    a_stop_clears: assert property (p_stop_clears) else $error("clock not withheld after stop");

endmodule

// ==== clock_gen_wakeup_timer.sv ====
// clock source selection, cpu clock divider, clock output and trim register
`timescale 1ns/1ps
`include "clkgen_regs.svh"

module clock_gen_wakeup_timer (
    // clock and resets
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic por_n,
    // register bus
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // stored configuration
    input wire clkgen_pkg::osc_src_e cfg_source,
    input wire logic cfg_rtc_xtal,
    // power control
    input wire logic osc_enable,
    // oscillator and clock pins
    input wire logic rc_osc_clock,
    input wire logic wdt_osc_clock,
    input wire logic xtal_osc_clock,
    input wire logic ext_clock_in_pin,
    output logic crystal_out_clock_pin_o,
    output logic crystal_out_clock_pin_oe,
    // derived clock enables
    output logic cpu_core_clock,
    output logic periph_clock_en,
    output logic machine_cycle,
    output logic cpu_clock_running,
    // analogue trim
    output logic [5:0] rc_trim
);
    import clkgen_pkg::*;

    localparam int PIN_RC = 0;
    localparam int PIN_WDT = 1;
    localparam int PIN_XTAL = 2;
    localparam int PIN_EXT = 3;

    // ============================================================
    // pin synchronisers
    logic [3:0] pin_raw;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync3;

    assign pin_raw = {ext_clock_in_pin, xtal_osc_clock, wdt_osc_clock, rc_osc_clock};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    sync1[gi] <= 1'b0;
                    sync2[gi] <= 1'b0;
                    sync3[gi] <= 1'b0;
                end else begin
                    sync1[gi] <= pin_raw[gi];
                    sync2[gi] <= sync1[gi];
                    sync3[gi] <= sync2[gi];
                end
            end
        end
    endgenerate

    // ============================================================
    // configuration capture
    osc_src_e src_q, next_src;
    logic rtc_xtal_q, next_rtc_xtal;
    logic cfg_loaded, next_cfg_loaded;

    always_comb begin
        next_src = src_q;
        next_rtc_xtal = rtc_xtal_q;
        next_cfg_loaded = 1'b1;
        // the choice is latched once after reset and never follows later changes
        if (!cfg_loaded) begin
            next_src = cfg_source;
            next_rtc_xtal = cfg_rtc_xtal;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            src_q <= src_rc;
            rtc_xtal_q <= 1'b0;
            cfg_loaded <= 1'b0;
        end else begin
            src_q <= next_src;
            rtc_xtal_q <= next_rtc_xtal;
            cfg_loaded <= next_cfg_loaded;
        end
    end

    // ============================================================
    // oscillator clock selection
    logic xtal_sel;
    logic [1:0] pin_idx;
    logic osc_tick;

    always_comb begin
        xtal_sel = 1'b0;
        pin_idx = 2'(PIN_RC);
        case (src_q)
            src_xtal_low, src_xtal_med, src_xtal_high: begin
                xtal_sel = 1'b1;
                pin_idx = 2'(PIN_XTAL);
            end
            src_rc: begin
                pin_idx = 2'(PIN_RC);
            end
            src_wdt: begin
                pin_idx = 2'(PIN_WDT);
            end
            src_ext: begin
                pin_idx = 2'(PIN_EXT);
            end
            default: begin
                pin_idx = 2'(PIN_RC);
            end
        endcase
    end

    // a stopped input simply gives no ticks, so any rate down to zero is fine
    assign osc_tick = cfg_loaded && sync2[pin_idx] && !sync3[pin_idx];

    // ============================================================
    // wake-up timer
    logic osc_en_q;
    logic wake_start;
    logic wake_done;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_en_q <= 1'b0;
        end else begin
            osc_en_q <= osc_enable && cfg_loaded;
        end
    end

    assign wake_start = osc_enable && cfg_loaded && !osc_en_q;

    clkgen_wake_timer u_wake (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .start(wake_start),
        .stop(!osc_enable),
        .osc_tick(osc_tick),
        .long_wait(xtal_sel),
        .done(wake_done)
    );

    // ============================================================
    // register bus
    logic ack_q, next_ack;
    logic [31:0] rdata_q, next_rdata;
    logic [`CG_DIV_W-1:0] div_q, next_div;
    logic [5:0] trim_q, next_trim;
    logic clkout_en_q, next_clkout_en;
    logic bus_req;
    logic trim_wr;
    logic div_wr;

    assign bus_req = avs_read || avs_write;
    assign avs_waitrequest = bus_req && !ack_q;
    assign trim_wr = avs_write && ack_q && avs_address == `CG_TRIM_OFS;
    assign div_wr = avs_write && ack_q && avs_address == `CG_DIV_OFS;

    always_comb begin
        next_ack = bus_req && !ack_q;
        next_rdata = rdata_q;
        if (avs_read && !ack_q) begin
            case (avs_address)
                `CG_TRIM_OFS: begin
                    next_rdata = 32'({clkout_en_q, trim_q});
                end
                `CG_DIV_OFS: begin
                    next_rdata = 32'(div_q);
                end
                `CG_STAT_OFS: begin
                    next_rdata = 32'({rtc_xtal_q, src_q, crystal_out_clock_pin_oe, wake_done});
                end
                default: begin
                    next_rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= next_ack;
            rdata_q <= next_rdata;
        end
    end

    assign avs_readdata = rdata_q;

    // ============================================================
    // trim register, kept across every reset but power-on
    always_comb begin
        next_trim = trim_q;
        next_clkout_en = clkout_en_q;
        if (trim_wr) begin
            next_trim = avs_writedata[`CG_TRIM_LSB +: `CG_TRIM_W];
            next_clkout_en = avs_writedata[`CG_CLKOUT_EN_BIT];
        end
    end

    always_ff @(posedge core_clk or negedge por_n) begin
        if (!por_n) begin
            trim_q <= `CG_FACTORY_TRIM;
            clkout_en_q <= 1'b0;
        end else begin
            trim_q <= next_trim;
            clkout_en_q <= next_clkout_en;
        end
    end

    assign rc_trim = trim_q;

    // ============================================================
    // cpu clock divider
    logic [8:0] div_cnt, next_div_cnt;
    logic [8:0] div_limit;
    logic cpu_tick;

    // factor is twice the setting, zero meaning undivided, so 255 gives 510
    assign div_limit = (div_q == 8'h00) ? 9'h001 : {div_q, 1'b0};
    // the compare tolerates a shrinking factor, so a rewrite never stalls the cpu
    assign cpu_tick = wake_done && osc_tick && (div_cnt >= div_limit - 9'h001);

    always_comb begin
        next_div = div_q;
        next_div_cnt = div_cnt;
        if (div_wr) begin
            next_div = avs_writedata[`CG_DIV_W-1:0];
        end
        if (!wake_done) begin
            next_div_cnt = 9'h000;
        end else if (cpu_tick) begin
            next_div_cnt = 9'h000;
        end else if (osc_tick) begin
            next_div_cnt = div_cnt + 9'h001;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= `CG_DIV_RESET;
            div_cnt <= 9'h000;
        end else begin
            div_q <= next_div;
            div_cnt <= next_div_cnt;
        end
    end

    // ============================================================
    // cpu, peripheral and machine cycle enables, clock output pin
    logic phase_q, next_phase;
    logic cpu_q, next_cpu;
    logic pair_q, next_pair;
    logic clkout_q, next_clkout;
    logic clkout_oe_q, next_clkout_oe;
    logic clkout_allowed;

    // the crystal pin is busy while the crystal feeds the core or the rtc
    // gated until capture, else the reset default source would open the pin for one cycle
    assign clkout_allowed = cfg_loaded && !xtal_sel && !rtc_xtal_q && clkout_en_q;

    always_comb begin
        next_cpu = cpu_tick;
        next_pair = cpu_tick && phase_q;
        next_phase = phase_q;
        next_clkout = 1'b0;
        next_clkout_oe = clkout_allowed;
        if (cpu_tick) begin
            next_phase = !phase_q;
        end
        if (!wake_done) begin
            next_phase = 1'b0;
        end
        if (clkout_allowed) begin
            next_clkout = cpu_tick ? !clkout_q : clkout_q;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= 1'b0;
            cpu_q <= 1'b0;
            pair_q <= 1'b0;
            clkout_q <= 1'b0;
            clkout_oe_q <= 1'b0;
        end else begin
            phase_q <= next_phase;
            cpu_q <= next_cpu;
            pair_q <= next_pair;
            clkout_q <= next_clkout;
            clkout_oe_q <= next_clkout_oe;
        end
    end

    assign cpu_core_clock = cpu_q;
    assign periph_clock_en = pair_q;
    assign machine_cycle = pair_q;
    assign cpu_clock_running = wake_done;
    assign crystal_out_clock_pin_o = clkout_q;
    assign crystal_out_clock_pin_oe = clkout_oe_q;

    // ============================================================
    // checks
    sequence s_pending;
        bus_req && avs_waitrequest;
    endsequence

    sequence s_second_cpu;
        cpu_tick && phase_q;
    endsequence

    property p_wait_one;
        @(posedge core_clk) disable iff (!rst_n)
        s_pending |=> !avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("bus answer late");

    property p_div_write;
        @(posedge core_clk) disable iff (!rst_n)
        avs_write && !avs_waitrequest && avs_address == 4'h4 |=> div_q == $past(avs_writedata[7:0]);
    endproperty
    a_div_write: assert property (p_div_write) else $error("divider write lost");

    property p_pair_rate;
        @(posedge core_clk) disable iff (!rst_n)
        s_second_cpu |=> pair_q && cpu_q;
    endproperty
    a_pair_rate: assert property (p_pair_rate) else $error("peripheral enable missing");

    property p_pair_needs_cpu;
        @(posedge core_clk) disable iff (!rst_n)
        pair_q |-> cpu_q && !phase_q;
    endproperty
    a_pair_needs_cpu: assert property (p_pair_needs_cpu) else $error("peripheral enable off rate");

    property p_clkout_gate;
        @(posedge core_clk) disable iff (!rst_n)
        clkout_oe_q |-> $past(cfg_loaded && !xtal_sel && !rtc_xtal_q && clkout_en_q);
    endproperty
    a_clkout_gate: assert property (p_clkout_gate) else $error("clock output driven while barred");

    property p_clkout_toggle;
        @(posedge core_clk) disable iff (!rst_n)
        cpu_q && clkout_oe_q && $past(clkout_oe_q) |-> clkout_q != $past(clkout_q);
    endproperty
    a_clkout_toggle: assert property (p_clkout_toggle) else $error("clock output did not toggle");

    property p_gated;
        @(posedge core_clk) disable iff (!rst_n)
        !wake_done |=> !cpu_q;
    endproperty
    a_gated: assert property (p_gated) else $error("cpu clock during wake delay");

    property p_src_fixed;
        @(posedge core_clk) disable iff (!rst_n)
        cfg_loaded |=> $stable(src_q) && $stable(rtc_xtal_q);
    endproperty
    a_src_fixed: assert property (p_src_fixed) else $error("source changed after capture");

    property p_trim_hold;
        @(posedge core_clk) disable iff (!por_n)
        $changed(trim_q) |-> $past(trim_wr);
    endproperty
    a_trim_hold: assert property (p_trim_hold) else $error("trim changed without write");

endmodule

// ==== osc_model.sv ====
// free-running oscillator pins that feed the clock unit
`timescale 1ns/1ps
module osc_model (
    // clock
    input wire logic core_clk,
    // oscillator pins
    output logic rc_osc_clock,
    output logic wdt_osc_clock,
    output logic xtal_osc_clock,
    output logic ext_clock_in_pin
);
    // ============================================================
    // two high and two low per tick, half the fastest rate the pin sync takes
    logic [1:0] phase = 2'h0;
    // pins run at a quarter of core_clk, below the rate that needs the reset pin
    always_ff @(posedge core_clk) begin
        phase <= phase + 2'h1;
    end
    // oscillators run free, so the pins never stand still
    assign rc_osc_clock = phase[1];
    assign wdt_osc_clock = phase[1];
    assign xtal_osc_clock = phase[1];
    assign ext_clock_in_pin = phase[1];
endmodule

// ==== tb.sv ====
// self-checking bench of the clock generation unit
`timescale 1ns/1ps
`include "clkgen_regs.svh"
module tb;
    import clkgen_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic por_n = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    osc_src_e cfg_source = src_rc;
    logic cfg_rtc_xtal = 1'b0;
    logic osc_enable = 1'b0;
    logic rc_osc_clock, wdt_osc_clock, xtal_osc_clock, ext_clock_in_pin;
    logic pin_o, pin_oe, cpu_clk, periph, mcyc, running;
    logic [5:0] rc_trim;
    logic [31:0] rd;
    int failures = 0;
    int compares = 0;
    int cycles = 0;
    int n_cpu, n_per, n_mc, n_tog;
    logic [7:0] divs [4] = '{8'h00, 8'h01, 8'h03, 8'hff};
    int wins [4] = '{800, 800, 1200, 8160};
    osc_src_e srcs [5] = '{src_xtal_low, src_xtal_med, src_wdt, src_rc, src_ext};
    logic rtcs [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    logic oes [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};

    osc_model u_osc (.core_clk(core_clk), .rc_osc_clock(rc_osc_clock), .wdt_osc_clock(wdt_osc_clock),
        .xtal_osc_clock(xtal_osc_clock), .ext_clock_in_pin(ext_clock_in_pin));

    clock_gen_wakeup_timer u_dut (.core_clk(core_clk), .rst_n(rst_n), .por_n(por_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .cfg_source(cfg_source), .cfg_rtc_xtal(cfg_rtc_xtal), .osc_enable(osc_enable),
        .rc_osc_clock(rc_osc_clock), .wdt_osc_clock(wdt_osc_clock), .xtal_osc_clock(xtal_osc_clock),
        .ext_clock_in_pin(ext_clock_in_pin), .crystal_out_clock_pin_o(pin_o),
        .crystal_out_clock_pin_oe(pin_oe), .cpu_core_clock(cpu_clk), .periph_clock_en(periph),
        .machine_cycle(mcyc), .cpu_clock_running(running), .rc_trim(rc_trim));

    // ============================================================
    // clock and hang guard
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            failures++;
            test_done();
        end
    end

    // ============================================================
    // reporting
    task automatic test_done();
        if (failures == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_count(input int got, input int lo, input int hi);
        compares++;
        if (got < lo || got > hi) begin
            failures++;
            $display("Error at %0t: count %h outside %h to %h", $time, got, lo, hi);
        end
    endtask

    // ============================================================
    // avalon master: hold until waitrequest is sampled low at a rising edge, release at that edge
    task automatic bus_access(input logic wr, input logic [3:0] addr, input logic [31:0] wd);
        int n;
        @(posedge core_clk);
        avs_address <= addr;
        avs_writedata <= wd;
        avs_read <= !wr;
        avs_write <= wr;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            failures++;
            test_done();
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic bus_read(input logic [3:0] addr, input logic [31:0] exp);
        bus_access(1'b0, addr, 32'h0);
        cmp_word(rd, exp);
    endtask

    // ============================================================
    // reset, wake-up and pulse counting
    task automatic do_reset(input osc_src_e src, input logic rtc, input logic por);
        @(posedge core_clk);
        rst_n <= 1'b0;
        por_n <= !por;
        osc_enable <= 1'b0;
        cfg_source <= src;
        cfg_rtc_xtal <= rtc;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        repeat (3) @(posedge core_clk);
    endtask
    // cpu clock must stay held for the whole quiet span, then start soon after
    task automatic wake_check(input int quiet, input int limit);
        int n;
        osc_enable <= 1'b1;
        repeat (quiet) @(posedge core_clk);
        cmp_word({31'h0, running}, 32'h0);
        n = 0;
        while (running !== 1'b1 && n < limit) begin
            @(posedge core_clk);
            n++;
        end
        cmp_count(n, 1, limit - 1);
    endtask
    task automatic count_pulses(input int w);
        logic last;
        n_cpu = 0;
        n_per = 0;
        n_mc = 0;
        n_tog = 0;
        last = pin_o;
        repeat (w) begin
            @(posedge core_clk);
            n_cpu += (cpu_clk === 1'b1);
            n_per += (periph === 1'b1);
            n_mc += (mcyc !== periph);
            n_tog += (pin_o !== last);
            last = pin_o;
        end
    endtask

    // ============================================================
    // main sequence
    initial begin
        int ex;
        do_reset(src_rc, 1'b0, 1'b1);
        bus_read(`CG_TRIM_OFS, 32'h20);
        bus_read(`CG_DIV_OFS, 32'h0);
        bus_read(`CG_STAT_OFS, 32'h0c);
        bus_read(4'hc, 32'h0);
        bus_access(1'b1, `CG_TRIM_OFS, 32'hd5);
        bus_read(`CG_TRIM_OFS, 32'h55);
        cmp_word({26'h0, rc_trim}, 32'h15);
        bus_access(1'b1, `CG_STAT_OFS, 32'hff);
        bus_read(`CG_STAT_OFS, 32'h0e);
        wake_check(2390, 60);
        // ticks come every four cycles from the oscillator model
        foreach (divs[i]) begin
            ex = (divs[i] == 8'h00) ? wins[i] / 4 : wins[i] / (8 * int'(divs[i]));
            bus_access(1'b1, `CG_DIV_OFS, {24'h0, divs[i]});
            count_pulses(100);
            count_pulses(wins[i]);
            cmp_count(n_cpu, ex - 1, ex + 1);
            cmp_count(n_per * 2, n_cpu - 2, n_cpu + 2);
            cmp_count(n_mc, 0, 0);
            cmp_count(n_tog, n_cpu - 1, n_cpu + 1);
        end
        do_reset(src_xtal_high, 1'b0, 1'b0);
        bus_read(`CG_TRIM_OFS, 32'h55);
        bus_read(`CG_STAT_OFS, 32'h08);
        wake_check(3960, 60);
        bus_read(`CG_STAT_OFS, 32'h09);
        foreach (srcs[i]) begin
            do_reset(srcs[i], rtcs[i], 1'b0);
            bus_read(`CG_STAT_OFS, {26'h0, rtcs[i], 3'(srcs[i]), oes[i], 1'b0});
            cmp_word({31'h0, pin_oe}, {31'h0, oes[i]});
        end
        // clock output switched off as software would before idle
        bus_access(1'b1, `CG_TRIM_OFS, 32'h15);
        repeat (4) @(posedge core_clk);
        cmp_word({30'h0, pin_oe, pin_o}, 32'h0);
        do_reset(src_rc, 1'b0, 1'b1);
        bus_read(`CG_TRIM_OFS, 32'h20);
        test_done();
    end
endmodule
